// ---- hdl/acsm_channel_ctrl.sv ----
// Channel selection, mux output routing and conversion control
`include "acsm_consts.svh"

module acsm_channel_ctrl #(
    parameter int CONV_CLOCKS = `ACSM_CONV_CLOCKS,
    parameter int SAMPLE_CLOCKS = `ACSM_SAMPLE_CLOCKS,
    parameter int PSC_DIV_SLOW = `ACSM_PSC_DIV_SLOW
) (
    input wire logic ref_clk, // 40 MHz system clock
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic clk_en, // Freezes all state while low
    input wire logic [3:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic busy_set, // Single-bit set of busy alone
    output logic [7:0] reg_rdata, // Read data, cycle after strobe
    output logic [15:0] pos_sel, // One-hot positive input channel
    output logic [15:0] neg_sel, // One-hot negative input channel
    output logic neg_is_ground, // Negative input tied to ground
    output logic mux_pos_pin_en, // Mux output driven onto ch14 pin
    output logic mux_neg_pin_en, // Negative mux output onto ch13 pin
    output logic adc_in_pin_en, // Converter input taken from ch15 pin
    output logic sample_on, // Sample switch closed
    output logic conv_clk_en, // Converter clock running
    output logic conv_done // One-cycle pulse at completion
);
    initial begin
        if (CONV_CLOCKS <= SAMPLE_CLOCKS || CONV_CLOCKS > 255)
            $error("CONV_CLOCKS out of range");
        if (SAMPLE_CLOCKS < 1 || PSC_DIV_SLOW < 2 || PSC_DIV_SLOW > 256)
            $error("sample or prescale out of range");
    end

    localparam logic [7:0] CONV_LAST = 8'(CONV_CLOCKS - 1);
    localparam logic [7:0] SAMPLE_LAST = 8'(SAMPLE_CLOCKS - 1);
    localparam logic [7:0] PSC_LAST = 8'(PSC_DIV_SLOW - 1);

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    logic [3:0] chan_q;
    logic mode_q;
    logic muxout_q;
    logic psc_q;
    logic busy_q;
    logic finish;
    logic ctrl_wr;
    logic run_wr;

    assign ctrl_wr = reg_wr && (reg_addr == `ACSM_CTRL_ADDR);
    // A start is any write that sets busy, or the single-bit set
    assign run_wr = (ctrl_wr && reg_wdata[`ACSM_BIT_BUSY]) || busy_set;

    // Settings only change while idle so a running conversion is stable
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            chan_q <= 4'h0;
            mode_q <= 1'b0;
            muxout_q <= 1'b0;
            psc_q <= 1'b0;
        end else if (clk_en && ctrl_wr && !busy_q) begin
            chan_q <= reg_wdata[`ACSM_CH_MSB:`ACSM_CH_LSB];
            mode_q <= reg_wdata[`ACSM_BIT_MODE];
            muxout_q <= reg_wdata[`ACSM_BIT_MUXOUT];
            psc_q <= reg_wdata[`ACSM_BIT_PSC];
        end
    end

    // Busy: a start sets it; a software clear or completion drops it.
    // A start is only taken while idle, so a restart needs a clear first.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            busy_q <= 1'b0;
        end else if (clk_en) begin
            if (run_wr && !busy_q)
                busy_q <= 1'b1;
            else if (ctrl_wr && !reg_wdata[`ACSM_BIT_BUSY])
                busy_q <= 1'b0;
            else if (finish)
                busy_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Prescaler and conversion sequencer
    // ----------------------------------------------------------------
    logic [7:0] psc_cnt_q;
    logic tick;
    logic [7:0] step_q;
    acsm_pkg::acsm_state_e state_q;

    // Converter clock tick: every cycle or one in PSC_DIV_SLOW
    assign tick = busy_q && (!psc_q || psc_cnt_q == PSC_LAST);

    // Prescaler is held cleared while idle to save switching power
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            psc_cnt_q <= 8'h00;
        end else if (clk_en) begin
            if (!busy_q || psc_cnt_q == PSC_LAST)
                psc_cnt_q <= 8'h00;
            else
                psc_cnt_q <= psc_cnt_q + 8'h01;
        end
    end

    assign finish = tick && state_q == acsm_pkg::ACSM_CONVERT && step_q == CONV_LAST;

    // Sample for the first clocks, then convert to the last clock
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= acsm_pkg::ACSM_IDLE;
            step_q <= 8'h00;
        end else if (clk_en) begin
            if (!busy_q) begin
                state_q <= acsm_pkg::ACSM_IDLE;
                step_q <= 8'h00;
            end else if (ctrl_wr && !reg_wdata[`ACSM_BIT_BUSY]) begin
                state_q <= acsm_pkg::ACSM_IDLE;
                step_q <= 8'h00;
            end else if (tick) begin
                unique case (state_q)
                    acsm_pkg::ACSM_IDLE: begin
                        state_q <= acsm_pkg::ACSM_SAMPLE;
                        step_q <= 8'h00;
                    end
                    acsm_pkg::ACSM_SAMPLE: begin
                        step_q <= step_q + 8'h01;
                        if (step_q == SAMPLE_LAST)
                            state_q <= acsm_pkg::ACSM_CONVERT;
                    end
                    acsm_pkg::ACSM_CONVERT: begin
                        step_q <= step_q + 8'h01;
                        if (step_q == CONV_LAST)
                            state_q <= acsm_pkg::ACSM_IDLE;
                    end
                    default: begin
                        state_q <= acsm_pkg::ACSM_IDLE;
                        step_q <= 8'h00;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Channel routing
    // ----------------------------------------------------------------
    logic [3:0] neg_ch;
    logic path_on;
    logic code_usable;

    // Partner channel of a differential pair: flip the low bit
    assign neg_ch = {chan_q[3:1], ~chan_q[0]};
    // Mux-out keeps the path live while idle so the filter can settle
    assign path_on = busy_q || muxout_q;
    // With mux-out only codes 0..13 (0..11 differential) are usable
    assign code_usable = !muxout_q || (mode_q ? chan_q < 4'hc : chan_q < `ACSM_CH_MUXOUT_POS);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pos_sel <= 16'h0000;
            neg_sel <= 16'h0000;
            neg_is_ground <= 1'b1;
            mux_pos_pin_en <= 1'b0;
            mux_neg_pin_en <= 1'b0;
            adc_in_pin_en <= 1'b0;
        end else if (clk_en) begin
            pos_sel <= (path_on && code_usable) ? (16'h0001 << chan_q) : 16'h0000;
            // Negative side follows mode and mux-out, not the code alone
            neg_sel <= (path_on && code_usable && mode_q) ? (16'h0001 << neg_ch) : 16'h0000;
            neg_is_ground <= !mode_q;
            mux_pos_pin_en <= muxout_q;
            mux_neg_pin_en <= muxout_q && mode_q;
            adc_in_pin_en <= muxout_q;
        end
    end

    // Converter clock, sample switch and completion pulse
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sample_on <= 1'b0;
            conv_clk_en <= 1'b0;
            conv_done <= 1'b0;
        end else if (clk_en) begin
            sample_on <= state_q == acsm_pkg::ACSM_SAMPLE;
            conv_clk_en <= busy_q;
            conv_done <= finish;
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            if (reg_rd && reg_addr == `ACSM_CTRL_ADDR)
                reg_rdata <= {chan_q, mode_q, muxout_q, psc_q, busy_q};
            else if (reg_rd && reg_addr == `ACSM_STAT_ADDR)
                reg_rdata <= {5'h00, state_q};
            else
                reg_rdata <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence busy_write_s;
        ctrl_wr && busy_q && clk_en;
    endsequence

    AST_LOCK_WHILE_BUSY: assert property (@(posedge ref_clk) disable iff (!resetn)
        busy_write_s |=> $stable(chan_q) && $stable(mode_q) && $stable(psc_q))
        else $error("settings changed during conversion");
    AST_DONE_CLEARS_BUSY: assert property (@(posedge ref_clk) disable iff (!resetn)
        (finish && clk_en && !run_wr) |=> !busy_q && conv_done)
        else $error("busy not cleared at completion");
    AST_START: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && run_wr && !busy_q) |=> busy_q)
        else $error("start not taken");
    AST_POS_ONEHOT: assert property (@(posedge ref_clk) disable iff (!resetn)
        $onehot0(pos_sel) && $onehot0(neg_sel))
        else $error("more than one channel selected");
    AST_SINGLE_NEG: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && !mode_q) |=> neg_sel == 16'h0000 && neg_is_ground)
        else $error("single-ended has negative channel");
    AST_PAIR: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && mode_q && !muxout_q && busy_q) |=> neg_sel == (16'h0001 << neg_ch))
        else $error("differential pair wrong");
    AST_IDLE_ROUTE: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && muxout_q && !busy_q && chan_q < 4'hc) |=> pos_sel != 16'h0000 && adc_in_pin_en)
        else $error("mux-out path not live while idle");
    AST_NEG_PIN: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && !muxout_q) |=> !mux_pos_pin_en && !mux_neg_pin_en && !adc_in_pin_en)
        else $error("reassigned pins not released");
    AST_NO_14_15: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && muxout_q && chan_q >= 4'he) |=> pos_sel == 16'h0000)
        else $error("reserved code routed");
    AST_DIFF_PINS: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && muxout_q && mode_q) |=> mux_pos_pin_en && mux_neg_pin_en)
        else $error("differential mux pins missing");
    AST_SE_PINS: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && muxout_q && !mode_q) |=> mux_pos_pin_en && !mux_neg_pin_en)
        else $error("single-ended mux pins wrong");

    // ----------------------------------------------------------------
    // Sequencing, bus and clock enable checks
    // ----------------------------------------------------------------
    // An accepted start and a software stop, the two steps of a restart
    sequence start_s;
        clk_en && run_wr && !busy_q;
    endsequence

    sequence stop_s;
        clk_en && busy_q && ctrl_wr && !reg_wdata[`ACSM_BIT_BUSY];
    endsequence

    // The converter clock follows busy one cycle behind, two cycles after the start
    AST_START_CLOCK: assert property (@(posedge ref_clk) disable iff (!resetn)
        start_s ##1 (busy_q && clk_en) |=> conv_clk_en)
        else $error("converter clock not started");

    // Writing busy low while running stops at once
    AST_STOP: assert property (@(posedge ref_clk) disable iff (!resetn)
        stop_s |=> !busy_q && state_q == acsm_pkg::ACSM_IDLE)
        else $error("conversion not stopped");

    // Mux-out enable is locked too, not only channel and mode
    AST_MUXOUT_LOCK: assert property (@(posedge ref_clk) disable iff (!resetn)
        busy_write_s |=> $stable(muxout_q))
        else $error("mux-out changed during conversion");

    // Busy alone leaves every other field as it was
    AST_BUSY_ALONE: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && busy_set && !ctrl_wr) |=> $stable(chan_q) && $stable(mode_q)
            && $stable(muxout_q) && $stable(psc_q))
        else $error("busy set disturbed settings");

    // Idle keeps the sequencer parked at its first step
    AST_IDLE_PARK: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && !busy_q) |=> state_q == acsm_pkg::ACSM_IDLE && step_q == 8'h00)
        else $error("sequencer running while idle");

    // First converter clock after a start opens the sample window
    AST_SAMPLE_ENTRY: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && busy_q && tick && !ctrl_wr && state_q == acsm_pkg::ACSM_IDLE)
            |=> state_q == acsm_pkg::ACSM_SAMPLE)
        else $error("sample window not opened");

    // The sample window closes after its last clock
    AST_CONVERT_ENTRY: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && tick && !ctrl_wr && state_q == acsm_pkg::ACSM_SAMPLE
            && step_q == SAMPLE_LAST) |=> state_q == acsm_pkg::ACSM_CONVERT)
        else $error("sample window not closed");

    // Sample switch mirrors the sample state one cycle later
    AST_SAMPLE_FLAG: assert property (@(posedge ref_clk) disable iff (!resetn)
        clk_en |=> sample_on == ($past(state_q) == acsm_pkg::ACSM_SAMPLE))
        else $error("sample switch out of step");

    // Converter clock gating follows busy, off when idle to save power
    AST_CLOCK_FOLLOWS: assert property (@(posedge ref_clk) disable iff (!resetn)
        clk_en |=> conv_clk_en == $past(busy_q))
        else $error("converter clock not following busy");

    // Completion is a single-cycle pulse
    AST_DONE_PULSE: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && conv_done) |=> !conv_done)
        else $error("completion pulse too long");

    // Read data stands for one cycle only
    AST_RDATA_IDLE: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && !reg_rd) |=> reg_rdata == 8'h00)
        else $error("read data not cleared");

    // Control read returns channel in the top nibble and busy at bit 0
    AST_RDATA_CTRL: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && reg_rd && reg_addr == `ACSM_CTRL_ADDR)
            |=> reg_rdata[7:4] == $past(chan_q) && reg_rdata[0] == $past(busy_q))
        else $error("control read wrong");

    // Differential mode never ties the negative input to ground
    AST_NEG_DIFF: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && mode_q) |=> !neg_is_ground)
        else $error("negative input grounded in differential mode");

    // Without mux-out an idle converter connects no channel
    AST_IDLE_OFF: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && !busy_q && !muxout_q) |=> pos_sel == 16'h0000 && neg_sel == 16'h0000)
        else $error("channel connected while idle");

    // Mux-out routes both the output pin and the converter input pin
    AST_MUX_PINS: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && muxout_q) |=> mux_pos_pin_en && adc_in_pin_en)
        else $error("mux-out pins not routed");

    // Sequencer state stays one-hot
    AST_STATE_ONEHOT: assert property (@(posedge ref_clk) disable iff (!resetn)
        $onehot(state_q))
        else $error("sequencer state not one-hot");

    // Clock enable low freezes every register
    AST_FREEZE: assert property (@(posedge ref_clk) disable iff (!resetn)
        !clk_en |=> $stable(busy_q) && $stable(state_q) && $stable(chan_q)
            && $stable(reg_rdata) && $stable(pos_sel))
        else $error("state moved while frozen");
endmodule // acsm_channel_ctrl

// ---- inc/acsm_consts.svh ----
// Constants for the converter channel select and multiplexor output control
`ifndef ACSM_CONSTS_SVH
`define ACSM_CONSTS_SVH
// Functional notes
// - Four-bit field picks positive input channel
// - Negative input from mode and mux-out bits
// - Mux-out off: all sixteen codes, pairs n/n^1
// - Mux-out on: fourteen channels selectable, twelve differential
// - Single-ended mux-out: out on 14, input 15
// - Differential mux-out: plus 14, minus 13
// - Mux-out keeps channel routed even when idle
// - Mux-out keeps converter input path connected
// - Hardware clears busy when conversion finishes
// - Start by full write or busy bit alone
// - Register: channel, mode, mux-out, prescale, busy
// - Mode bit: 0 single-ended, 1 differential
// - Writes ignored while busy, except busy bit

// ----------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------
`define ACSM_CTRL_ADDR 4'h0
`define ACSM_STAT_ADDR 4'h1
`define ACSM_CTRL_RESET 8'h00
`define ACSM_BIT_BUSY 0
`define ACSM_BIT_PSC 1
`define ACSM_BIT_MUXOUT 2
`define ACSM_BIT_MODE 3
`define ACSM_CH_LSB 4
`define ACSM_CH_MSB 7

// ----------------------------------------------------------------
// Pin channels and timing
// ----------------------------------------------------------------
`define ACSM_CH_MUXOUT_POS 4'he
`define ACSM_CH_ADC_IN 4'hf
`define ACSM_CH_MUXOUT_NEG 4'hd
`define ACSM_CONV_CLOCKS 15
`define ACSM_SAMPLE_CLOCKS 3
`define ACSM_PSC_DIV_SLOW 16
`endif

// ---- inc/acsm_pkg.sv ----
// Types for the converter channel select and multiplexor output control
package acsm_pkg;
    typedef enum logic [2:0] {
        ACSM_IDLE = 3'b001,
        ACSM_SAMPLE = 3'b010,
        ACSM_CONVERT = 3'b100
    } acsm_state_e;
endpackage

// ---- test/acsm_cond_model.sv ----
// Behavioural external conditioning circuit on the routed pins
module acsm_cond_model #(
    parameter int SETTLE = 6 // Round trip, longer than the sample window
) (
    input wire logic ref_clk, // System clock
    input wire logic resetn, // Reset, active low
    input wire logic [15:0] pos_sel, // Channel routed out
    input wire logic path_en, // Mux output and converter input routed
    output logic settled // Filter output has settled
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] sel_q;
    int cnt_q;
    // Any channel change restarts settling; pins are listened to, never driven
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sel_q <= 16'h0000;
            cnt_q <= 0;
        end else begin
            sel_q <= pos_sel;
            cnt_q <= (!path_en || pos_sel != sel_q) ? 0 : cnt_q + int'(cnt_q < SETTLE);
        end
    end
    assign settled = (cnt_q == SETTLE); // Only then may software start
endmodule // acsm_cond_model

// ---- test/adc_channel_select_muxout_tb_top.sv ----
// Self-checking bench for the channel select and mux output control
module adc_channel_select_muxout_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic busy_set = 1'b0;
    logic clk_en = 1'b1;
    logic cur_psc = 1'b0;
    int smp_n = 0;
    logic rd_seen = 1'b0;
    logic [7:0] reg_rdata;
    logic [15:0] pos_sel;
    logic [15:0] neg_sel;
    logic ngnd, mpos, mneg, adin, sample_on, cclk, conv_done, settled;
    logic [7:0] exp_q[$];
    int n_mismatch = 0;
    int checks = 0;

    // Clock, 25 ns period
    always #12.5 ref_clk = ~ref_clk;

    // Counts shortened so each conversion takes 9 cycles, or 36 with the prescaler
    acsm_channel_ctrl #(.CONV_CLOCKS(8), .SAMPLE_CLOCKS(3), .PSC_DIV_SLOW(4)) uut (
        .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .busy_set(busy_set),
        .reg_rdata(reg_rdata), .pos_sel(pos_sel), .neg_sel(neg_sel), .neg_is_ground(ngnd),
        .mux_pos_pin_en(mpos), .mux_neg_pin_en(mneg), .adc_in_pin_en(adin),
        .sample_on(sample_on), .conv_clk_en(cclk), .conv_done(conv_done));
    acsm_cond_model #(.SETTLE(6)) ext (.ref_clk(ref_clk), .resetn(resetn),
        .pos_sel(pos_sel), .path_en(mpos & adin), .settled(settled));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask
    task automatic pulse_busy();
        @(posedge ref_clk);
        busy_set <= 1'b1;
        @(posedge ref_clk);
        busy_set <= 1'b0;
    endtask
    // Routing outputs lag the register by a cycle, so look two falling edges on
    task automatic route(input logic [15:0] ep, input logic [15:0] en, input logic [4:0] pins,
                         input bit dn);
        repeat (2) @(negedge ref_clk);
        chk(pos_sel, ep);
        if (dn) chk(neg_sel, en);
        chk({11'h000, ngnd, mpos, mneg, adin, cclk}, {11'h000, pins});
    endtask
    task automatic wait_done();
        int i;
        for (i = 0; i < 300 && conv_done !== 1'b1; i++) @(negedge ref_clk);
        chk({15'h0000, conv_done}, 16'h0001);
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge ref_clk) begin
        if (rd_seen === 1'b1 && exp_q.size() > 0)
            chk({8'h00, reg_rdata}, {8'h00, exp_q.pop_front()});
        rd_seen <= reg_rd;
    end

    // Sample window length, counted over each conversion
    always @(posedge ref_clk) begin
        if (conv_done === 1'b1) begin
            chk(16'(smp_n), cur_psc ? 16'h000c : 16'h0003);
            smp_n = 0;
        end else if (sample_on === 1'b1) begin
            smp_n++;
        end
    end

    // Hang guard, well beyond the few thousand cycles the tests need
    initial begin
        #500us;
        n_mismatch++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int ch;
        int md;
        logic [7:0] s;
        logic [15:0] ep;
        void'($urandom(12));
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        route(16'h0000, 16'h0000, 5'h10, 1'b1);
        wr(4'h9, 8'hff);
        rd(4'h0, 8'h00);
        rd(4'h1, 8'h01);
        rd(4'h9, 8'h00);
        // Clock enable low: a start write and a read are both frozen out
        @(posedge ref_clk);
        clk_en <= 1'b0;
        wr(4'h0, 8'h5d);
        rd(4'h0, 8'h00);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        rd(4'h0, 8'h00);
        // Mux output off: every code in both modes, with a write attempt mid-run
        for (ch = 0; ch < 32; ch++) begin
            s = {ch[3:0], ch[4], 1'b0, 1'($urandom % 2), 1'b0};
            cur_psc = s[1];
            wr(4'h0, s | 8'h01);
            wr(4'h0, 8'($urandom) | 8'h01);
            rd(4'h0, s | 8'h01);
            route(16'h0001 << ch[3:0], ch[4] ? 16'h0001 << (ch[3:0] ^ 4'h1) : 16'h0000,
                  {~ch[4], 4'h1}, 1'b1);
            wait_done();
            rd(4'h0, s);
        end
        // Mux output on: routed while idle, then settle and start by busy alone
        for (ch = 0; ch < 32; ch++) begin
            s = {ch[3:0], ch[4], 1'b1, 1'b0, 1'b0};
            cur_psc = 1'b0;
            // Codes 14, 15 and differential 12, 13 stay unrouted
            ep = (ch[3:1] == 3'h7 || (ch[4] && ch[3:2] == 2'h3)) ? 16'h0000 : 16'h0001 << ch[3:0];
            wr(4'h0, s);
            route(ep, (ch[4] && ep != 16'h0000) ? 16'h0001 << (ch[3:0] ^ 4'h1) : 16'h0000,
                  {~ch[4], 1'b1, ch[4], 1'b1, 1'b0}, 1'b1);
            if (ep != 16'h0000) begin
                for (md = 0; md < 100 && settled !== 1'b1; md++) @(negedge ref_clk);
                pulse_busy();
                rd(4'h0, s | 8'h01);
                wait_done();
                rd(4'h0, s);
            end
        end
        repeat (3) @(posedge ref_clk);
        give_verdict();
    end
endmodule // adc_channel_select_muxout_tb_top
